// ---- hdl/pma_macrocell_array.sv ----
`timescale 1ns/1ps
module pma_macrocell_array (
    input wire logic clock,
    input wire logic rst,
    input pma_pkg::pma_bus_s busReq,
    input wire logic edgeLoad,
    input pma_pkg::pma_cell_s [15:0] cellTerms,
    input pma_pkg::pma_cfg_s [15:0] cellCfg,
    input wire logic [15:0] termGrant,
    input wire logic [15:0] directionBit,
    input wire logic logic_clock_pin,
    input wire logic address_latch_strobe,
    input wire logic [23:0] portPin,
    input wire logic [7:0] upperAddress,
    input wire logic [2:0] addrCapture,
    input pma_pkg::pma_in_e [23:0] inMode,
    input wire logic [5:0] inCtlFromStrobe,
    input wire logic [5:0] inCtlTerm,
    output logic [7:0] readData,
    output logic [15:0] cellOut,
    output logic [15:0] pinDrive,
    output logic [15:0] pinOeN,
    output logic [15:0] feedback,
    output logic [23:0] inputBus,
    output logic [23:0] addressBus
);
    import pma_pkg::*;

    // Pins and strobes cross from outside: two stages for pins and upper address, three for strobes
    logic [23:0] pinS1_q, pinS2_q;
    logic clkPinS1_q, clkPinS2_q, clkPinS3_q;
    logic alsS1_q, alsS2_q, alsS3_q;
    logic [7:0] upS1_q, upS2_q;
    always_ff @(posedge clock) begin
        pinS1_q <= portPin;
        pinS2_q <= pinS1_q;
        clkPinS1_q <= logic_clock_pin;
        clkPinS2_q <= clkPinS1_q;
        clkPinS3_q <= clkPinS2_q;
        alsS1_q <= address_latch_strobe;
        alsS2_q <= alsS1_q;
        alsS3_q <= alsS2_q;
        upS1_q <= upperAddress;
        upS2_q <= upS1_q;
    end
    wire clkPinRise = clkPinS2_q & ~clkPinS3_q;
    wire alsRise = alsS2_q & ~alsS3_q;

    // Usable terms: native for every cell, borrowed only when granted and free
    function automatic logic [MAXTERM-1:0] termMask(input int idx);
        logic [MAXTERM-1:0] m;
        int nat;
        int bor;
        m = '0;
        nat = (idx < NCELL) ? AB_NATIVE : BC_NATIVE;
        bor = (idx < NCELL) ? AB_BORROW : ((idx < NCELL + 4) ? BC_BORROW_LO : BC_BORROW_HI);
        for (int i = 0; i < MAXTERM; i++) begin
            if (i < nat + bor) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic int nativeCount(input int idx);
        return (idx < NCELL) ? AB_NATIVE : BC_NATIVE;
    endfunction

    // Write strobe loader
    pma_ld_e ldState_q, ldState_d;
    always_ff @(posedge clock) begin
        if (rst) begin
            ldState_q <= LD_IDLE;
        end else begin
            ldState_q <= ldState_d;
        end
    end
    always_comb begin
        case (ldState_q)
            LD_IDLE: ldState_d = busReq.wrStrobe ? LD_ACTIVE : LD_IDLE;
            LD_ACTIVE: ldState_d = busReq.wrStrobe ? LD_ACTIVE : LD_DONE;
            LD_DONE: ldState_d = busReq.wrStrobe ? LD_ACTIVE : LD_IDLE;
            default: ldState_d = LD_IDLE;
        endcase
    end
    // Idle after reset, so no false trailing edge follows reset
    wire trailEdge = (ldState_q == LD_ACTIVE) && !busReq.wrStrobe;
    wire loadNow = edgeLoad ? trailEdge : busReq.wrStrobe;

    logic [7:0] maskAb_q, maskBc_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            maskAb_q <= MASK_RESET;
            maskBc_q <= MASK_RESET;
        end else if (busReq.wrStrobe && busReq.sel == SEL_MASK_AB) begin
            maskAb_q <= busReq.data;
        end else if (busReq.wrStrobe && busReq.sel == SEL_MASK_BC) begin
            maskBc_q <= busReq.data;
        end
    end

    wire groupAbLoad = loadNow && busReq.sel == SEL_OUT_AB;
    wire groupBcLoad = loadNow && busReq.sel == SEL_OUT_BC;
    wire [15:0] cellLoad = {{8{groupBcLoad}} & ~maskBc_q,
                            {8{groupAbLoad}} & ~maskAb_q};

    // Output cells
    logic [15:0] ff_q;
    logic [15:0] ffClkQ_q;
    logic [15:0] comb;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : gCell
            logic [MAXTERM-1:0] avail;
            logic sum;
            logic xorOut;
            logic clkEv;
            logic nxt;
            always_comb begin
                avail = termMask(g);
                for (int i = 0; i < MAXTERM; i++) begin
                    // Borrowed slots need the donor grant and must not be claimed elsewhere
                    if (i >= nativeCount(g) && !(termGrant[g] && !cellTerms[g].own[i])) begin
                        avail[i] = 1'b0;
                    end
                end
                sum = |(cellTerms[g].terms & avail);
                xorOut = sum ^ cellCfg[g].polarity;
                case (cellCfg[g].ffType)
                    FF_D: nxt = xorOut;
                    FF_T: nxt = ff_q[g] ^ xorOut;
                    FF_JK: nxt = (xorOut & ~ff_q[g]) | (~cellTerms[g].kTerm & ff_q[g]);
                    FF_SR: nxt = xorOut | (ff_q[g] & ~cellTerms[g].kTerm);
                    default: nxt = xorOut;
                endcase
            end
            assign comb[g] = xorOut;
            // Product-term clock sampled for edge; pin clock already synchronised
            assign clkEv = cellCfg[g].clkFromPin ? clkPinRise
                           : (cellTerms[g].clkTerm & ~ffClkQ_q[g]);
            always_ff @(posedge clock) begin
                if (rst) begin
                    ff_q[g] <= OMC_FF_RESET[0];
                    ffClkQ_q[g] <= 1'b0;
                end else begin
                    ffClkQ_q[g] <= cellTerms[g].clkTerm;
                    if (cellLoad[g]) begin
                        ff_q[g] <= busReq.data[g % NCELL];
                    end else if (|cellTerms[g].clearTerm) begin
                        ff_q[g] <= 1'b0;
                    end else if (cellTerms[g].presetTerm) begin
                        ff_q[g] <= 1'b1;
                    end else if (clkEv) begin
                        ff_q[g] <= nxt;
                    end
                end
            end
            assign cellOut[g] = cellCfg[g].useReg ? ff_q[g] : comb[g];
            assign feedback[g] = cellOut[g];
            assign pinDrive[g] = cellCfg[g].toPin ? cellOut[g] : 1'b0;
            // Enable is active low on the pin
            assign pinOeN[g] = ~(cellCfg[g].toPin &&
                                 (!cellCfg[g].hasOeEq || cellTerms[g].oeTerm ||
                                  directionBit[g]));
        end
    endgenerate

    // Input cells; control term shared by four cells
    logic [23:0] inCell_q;
    logic [23:0] inCtl;
    logic [23:0] inCtlPrev_q;
    generate
        for (g = 0; g < 24; g++) begin : gIn
            assign inCtl[g] = inCtlFromStrobe[g / 4] ? alsS2_q : inCtlTerm[g / 4];
            always_ff @(posedge clock) begin
                if (rst) begin
                    inCell_q[g] <= 1'b0;
                    inCtlPrev_q[g] <= 1'b0;
                end else begin
                    inCtlPrev_q[g] <= inCtl[g];
                    if (inMode[g] == IN_LATCH && inCtl[g]) begin
                        inCell_q[g] <= pinS2_q[g];
                    end else if (inMode[g] == IN_REG && inCtl[g] && !inCtlPrev_q[g]) begin
                        inCell_q[g] <= pinS2_q[g];
                    end
                end
            end
            assign inputBus[g] = (inMode[g] == IN_PASS) ? pinS2_q[g] : inCell_q[g];
        end
    endgenerate

    // Upper address captured on the strobe, one byte per port
    logic [23:0] addr_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_q <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (addrCapture[p] && alsRise) begin
                    addr_q[p*8 +: 8] <= upS2_q;
                end
            end
        end
    end
    assign addressBus = addr_q;

    // Read buffer, registered data out
    wire [7:0] rdMux = (busReq.sel == SEL_OUT_AB) ? ff_q[7:0]
                     : (busReq.sel == SEL_OUT_BC) ? ff_q[15:8]
                     : (busReq.sel == SEL_MASK_AB) ? maskAb_q
                     : (busReq.sel == SEL_MASK_BC) ? maskBc_q
                     : (busReq.sel == SEL_IN_A) ? inputBus[7:0]
                     : (busReq.sel == SEL_IN_B) ? inputBus[15:8]
                     : (busReq.sel == SEL_IN_C) ? inputBus[23:16] : 8'h00;
    always_ff @(posedge clock) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (busReq.rdStrobe) begin
            readData <= rdMux;
        end
    end

    a_mask_blocks_load: assert property (@(posedge clock) disable iff (rst)
        (groupAbLoad && maskAb_q[0]) |=> $stable(ff_q[0]) || $past(|cellTerms[0].clearTerm)
            || $past(cellTerms[0].presetTerm) || $past(clkPinRise) || $past(cellTerms[0].clkTerm))
        else $error("masked cell changed on load");
    a_load_takes_data: assert property (@(posedge clock) disable iff (rst)
        cellLoad[3] |=> ff_q[3] == $past(busReq.data[3]))
        else $error("load data not stored");
    a_load_beats_clear: assert property (@(posedge clock) disable iff (rst)
        (cellLoad[9] && busReq.data[1] && |cellTerms[9].clearTerm) |=> ff_q[9])
        else $error("clear overrode load");
    a_mask_reset_zero: assert property (@(posedge clock)
        rst |=> maskAb_q == MASK_RESET && maskBc_q == MASK_RESET)
        else $error("mask not zero after reset");
    a_edge_load_time: assert property (@(posedge clock) disable iff (rst)
        (edgeLoad && busReq.wrStrobe) |-> !loadNow)
        else $error("edge load during strobe");
    a_oe_no_equation: assert property (@(posedge clock) disable iff (rst)
        (cellCfg[2].toPin && !cellCfg[2].hasOeEq) |-> !pinOeN[2])
        else $error("pin not driven without equation");
    a_feedback_select: assert property (@(posedge clock) disable iff (rst)
        feedback[5] == (cellCfg[5].useReg ? ff_q[5] : comb[5]))
        else $error("feedback mismatch");
    a_clear_acts: assert property (@(posedge clock) disable iff (rst)
        (!cellLoad[3] && cellTerms[3].clearTerm[1]) |=> !ff_q[3])
        else $error("clear ignored");
    a_read_group: assert property (@(posedge clock) disable iff (rst)
        (busReq.rdStrobe && busReq.sel == SEL_OUT_BC) |=> readData == $past(ff_q[15:8]))
        else $error("group read wrong");
    a_level_load_data: assert property (@(posedge clock) disable iff (rst)
        (!edgeLoad && busReq.wrStrobe && busReq.sel == SEL_OUT_AB && !maskAb_q[2])
            |=> ff_q[2] == $past(busReq.data[2]))
        else $error("level load missed");
    a_strobe_addr_capture: assert property (@(posedge clock) disable iff (rst)
        (alsRise && addrCapture[2]) |=> addressBus[23:16] == $past(upS2_q))
        else $error("upper address not captured");
    a_borrow_needs_grant: assert property (@(posedge clock) disable iff (rst)
        (!termGrant[0] && (|cellTerms[0].terms[9:3]) && cellTerms[0].terms[2:0] == 3'h0
            && !cellCfg[0].useReg) |-> cellOut[0] == cellCfg[0].polarity)
        else $error("borrowed term used without grant");
endmodule // pma_macrocell_array

// ---- hdl/pma_pkg.sv ----
// Contract
// - Two groups of eight output cells, first on ports A/B, second on B/C.
// - Each output cell XORs its summed product terms with a polarity bit.
// - Selector picks flip-flop or combinatorial value; selection always feeds back.
// - Output cell storage acts as D, T, JK or SR flip-flop.
// - Cell clock from product term or clock pin, rising edge.
// - Preset and clear from product terms, active high; clear ORs two terms.
// - First group cells own three terms, borrow up to six.
// - Second group owns four; cells 0-3 borrow five, 4-7 borrow six.
// - A term used by one cell is unusable elsewhere; fixed donor cells.
// - All sixteen flip-flops load from data bus; cell n uses bit n mod 8.
// - Processor load overrides internal clock, preset and clear.
// - Load on write strobe trailing edge or while strobe active.
// - One 8-bit mask per group, resetting to zero allowing loads.
// - Mask bit one blocks processor writes to that cell.
// - Pin driver enable is product term OR direction bit.
// - Logic output without enable equation is driven from power-up.
// - Internal-node cell still feeds back, pin left free.
// - Twenty-four input cells: latch, register or pass-through.
// - Input cell enable/clock from product term or address latch strobe.
// - One control term serves four cells: bits 3-0 and 7-4.
// - Processor reads input cells through a read buffer.
// - Strobe-clocked input cells capture upper address bits as array inputs.
// - Array inputs include all sixteen feedbacks, eight per group.
package pma_pkg;
    localparam int NCELL = 8;
    localparam int NPORT = 3;
    localparam int AB_NATIVE = 3;
    localparam int AB_BORROW = 6;
    localparam int BC_NATIVE = 4;
    localparam int BC_BORROW_LO = 5;
    localparam int BC_BORROW_HI = 6;
    localparam int MAXTERM = 10;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] OMC_FF_RESET = 2'h0;
    // Register selectors on the processor bus
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_OUT_AB = 3'h1;
    localparam logic [2:0] SEL_OUT_BC = 3'h2;
    localparam logic [2:0] SEL_MASK_AB = 3'h3;
    localparam logic [2:0] SEL_MASK_BC = 3'h4;
    localparam logic [2:0] SEL_IN_A = 3'h5;
    localparam logic [2:0] SEL_IN_B = 3'h6;
    localparam logic [2:0] SEL_IN_C = 3'h7;

    typedef enum logic [1:0] {
        FF_D = 2'h0,
        FF_T = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } pma_ff_e;

    typedef enum logic [1:0] {
        IN_PASS = 2'h0,
        IN_LATCH = 2'h1,
        IN_REG = 2'h2
    } pma_in_e;

    typedef enum logic [2:0] {
        LD_IDLE = 3'b001,
        LD_ACTIVE = 3'b010,
        LD_DONE = 3'b100
    } pma_ld_e;

    // Per-cell product term set from the AND array
    typedef struct packed {
        logic [MAXTERM-1:0] terms;
        logic [MAXTERM-1:0] own;
        logic clkTerm;
        logic presetTerm;
        logic [1:0] clearTerm;
        logic oeTerm;
        logic kTerm;
    } pma_cell_s;

    // Per-cell configuration
    typedef struct packed {
        logic polarity;
        logic useReg;
        logic clkFromPin;
        pma_ff_e ffType;
        logic toPin;
        logic hasOeEq;
    } pma_cfg_s;

    // Processor bus request
    typedef struct packed {
        logic [2:0] sel;
        logic wrStrobe;
        logic rdStrobe;
        logic [7:0] data;
    } pma_bus_s;
endpackage

// ---- testbench/pma_mcu_model.sv ----
`timescale 1ns/1ps
module pma_mcu_model (
    input wire logic clock,
    input wire logic [7:0] readData,
    output pma_pkg::pma_bus_s busReq,
    output logic [23:0] portPin
);
    import pma_pkg::*;
    logic [7:0] lastData;
    initial begin
        lastData = 8'h00;
        busReq = '0;
        portPin = 24'h000000;
    end
    // Released data lines show the inverse of the last byte, never a stale copy
    task automatic idle();
        busReq.sel = SEL_NONE;
        busReq.wrStrobe = 1'b0;
        busReq.rdStrobe = 1'b0;
        busReq.data = ~lastData;
    endtask
    // Select and data stay one cycle past the trailing edge, as a real host holds them
    task automatic write(input logic [2:0] sel, input logic [7:0] data);
        @(negedge clock);
        lastData = data;
        busReq.sel = sel;
        busReq.data = data;
        busReq.wrStrobe = 1'b1;
        @(negedge clock);
        busReq.wrStrobe = 1'b0;
        @(negedge clock);
        idle();
    endtask
    task automatic read(input logic [2:0] sel, output logic [7:0] data);
        @(negedge clock);
        busReq.sel = sel;
        busReq.rdStrobe = 1'b1;
        @(negedge clock);
        data = readData;
        idle();
    endtask
    task automatic pins(input logic [23:0] value);
        @(negedge clock);
        portPin = value;
    endtask
endmodule // pma_mcu_model

// ---- testbench/pma_macrocell_array_test.sv ----
`timescale 1ns/1ps
module pma_macrocell_array_test;
    import pma_pkg::*;
    logic clock, rst, edgeLoad, logicClockPin, addrStrobe;
    pma_bus_s busReq;
    pma_cell_s [15:0] cellTerms;
    pma_cfg_s [15:0] cellCfg;
    pma_in_e [23:0] inMode;
    logic [15:0] termGrant, directionBit, cellOut, pinDrive, pinOeN, feedback;
    logic [23:0] portPin, inputBus, addressBus;
    logic [7:0] upperAddress, readData;
    logic [2:0] addrCapture;
    logic [5:0] inCtlFromStrobe, inCtlTerm;
    int fails, checkCount;

    pma_macrocell_array u_dut (.clock(clock), .rst(rst), .busReq(busReq), .edgeLoad(edgeLoad),
        .cellTerms(cellTerms), .cellCfg(cellCfg), .termGrant(termGrant),
        .directionBit(directionBit), .logic_clock_pin(logicClockPin),
        .address_latch_strobe(addrStrobe), .portPin(portPin), .upperAddress(upperAddress),
        .addrCapture(addrCapture), .inMode(inMode), .inCtlFromStrobe(inCtlFromStrobe),
        .inCtlTerm(inCtlTerm), .readData(readData), .cellOut(cellOut), .pinDrive(pinDrive),
        .pinOeN(pinOeN), .feedback(feedback), .inputBus(inputBus), .addressBus(addressBus));
    pma_mcu_model u_mcu (.clock(clock), .readData(readData), .busReq(busReq), .portPin(portPin));

    always #20 clock = ~clock;

    task automatic check(input logic [23:0] seen, input logic [23:0] expected, input string what);
        checkCount++;
        if (seen !== expected) begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expected);
        end
    endtask
    task automatic rd(input logic [2:0] sel, input logic [7:0] expected, input string what);
        logic [7:0] value;
        u_mcu.read(sel, value);
        check({16'h0000, value}, {16'h0000, expected}, what);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic test_loads();
        rd(SEL_MASK_AB, MASK_RESET, "mask AB reset");
        rd(SEL_MASK_BC, MASK_RESET, "mask BC reset");
        rd(SEL_NONE, 8'h00, "unmapped read");
        u_mcu.write(SEL_MASK_AB, 8'h0F);
        u_mcu.write(SEL_OUT_AB, 8'hFF);
        rd(SEL_OUT_AB, 8'hF0, "masked AB");
        rd(SEL_MASK_AB, 8'h0F, "mask AB");
        u_mcu.write(SEL_OUT_BC, 8'hA5);
        rd(SEL_OUT_BC, 8'hA5, "load BC");
        check({8'h00, feedback}, 24'h00A5F0, "feedback");
        check({8'h00, cellOut}, 24'h00A5F0, "cells");
        u_mcu.write(SEL_MASK_AB, 8'h00);
        u_mcu.write(SEL_OUT_AB, 8'h3C);
        rd(SEL_OUT_AB, 8'h3C, "unmasked AB");
        edgeLoad = 1'b1;
        u_mcu.write(SEL_OUT_BC, 8'h5A);
        cycles(2);
        rd(SEL_OUT_BC, 8'h5A, "edge load");
        u_mcu.write(SEL_MASK_BC, 8'h80);
        u_mcu.write(SEL_OUT_BC, 8'hFF);
        cycles(2);
        rd(SEL_OUT_BC, 8'h7F, "edge masked");
        u_mcu.write(SEL_OUT_BC, 8'h00);
        cycles(2);
        rd(SEL_OUT_BC, 8'h00, "edge masked");
        edgeLoad = 1'b0;
        $display("loads done");
    endtask

    task automatic test_cells();
        cellTerms[3].clearTerm = 2'b10;
        cellTerms[6].presetTerm = 1'b1;
        cellTerms[9].clearTerm = 2'b01;
        u_mcu.write(SEL_OUT_BC, 8'h02);
        cycles(2);
        rd(SEL_OUT_AB, 8'h74, "clear preset");
        rd(SEL_OUT_BC, 8'h00, "clear after load");
        cellTerms[3].clearTerm = 2'b00;
        cellTerms[6].presetTerm = 1'b0;
        cellTerms[9].clearTerm = 2'b00;
        cellCfg[9].clkFromPin = 1'b1;
        cellCfg[9].polarity = 1'b1;
        cycles(4);
        check({23'h0, cellOut[9]}, 24'h000000, "no clock yet");
        logicClockPin = 1'b1;
        cycles(2);
        logicClockPin = 1'b0;
        cycles(6);
        check({23'h0, cellOut[9]}, 24'h000001, "pin clock");
        cellCfg[9].ffType = FF_T;
        logicClockPin = 1'b1;
        cycles(2);
        logicClockPin = 1'b0;
        cycles(6);
        check({23'h0, cellOut[9]}, 24'h000000, "toggle");
        cellCfg[10].useReg = 1'b0;
        cellCfg[10].polarity = 1'b1;
        cycles(1);
        check({22'h0, cellOut[10], feedback[10]}, 24'h000003, "polarity");
        cellCfg[10].useReg = 1'b1;
        cellCfg[10].polarity = 1'b0;
        $display("cells done");
    endtask

    task automatic test_pins();
        foreach (cellCfg[i]) cellCfg[i].hasOeEq = 1'b1;
        directionBit = 16'h00FF;
        cellTerms[8].oeTerm = 1'b1;
        cycles(1);
        check({8'h00, pinOeN}, 24'h00FE00, "enable or");
        foreach (cellCfg[i]) cellCfg[i].hasOeEq = 1'b0;
        directionBit = 16'h0000;
        cellTerms[8].oeTerm = 1'b0;
        cycles(1);
        check({8'h00, pinOeN}, 24'h000000, "no equation");
        check({8'h00, pinDrive}, 24'h000074, "pin data");
        foreach (cellCfg[i]) cellCfg[i].toPin = 1'b0;
        cycles(1);
        check({8'h00, pinOeN}, 24'h00FFFF, "nodes");
        check({8'h00, pinDrive}, 24'h000000, "node pins free");
        check({8'h00, feedback}, 24'h000074, "node feedback");
        $display("pins done");
    endtask

    task automatic test_terms();
        cellCfg[0].useReg = 1'b0;
        cellCfg[8].useReg = 1'b0;
        cellCfg[12].useReg = 1'b0;
        cellTerms[0].terms = 10'h010;
        cycles(1);
        check({23'h0, cellOut[0]}, 24'h000000, "borrow without grant");
        termGrant = 16'h1101;
        cycles(1);
        check({23'h0, cellOut[0]}, 24'h000001, "borrow granted");
        cellTerms[0].own = 10'h010;
        cycles(1);
        check({23'h0, cellOut[0]}, 24'h000000, "term taken");
        cellTerms[0].terms = 10'h200;
        cellTerms[8].terms = 10'h200;
        cellTerms[12].terms = 10'h200;
        cycles(1);
        check({21'h0, cellOut[12], cellOut[8], cellOut[0]}, 24'h000004, "borrow limits");
        $display("terms done");
    endtask

    task automatic test_strobe();
        for (int i = 16; i < 24; i++) inMode[i] = IN_REG;
        inCtlFromStrobe = 6'h30;
        addrCapture = 3'h4;
        upperAddress = 8'h6B;
        u_mcu.pins(24'h3C7E96);
        cycles(4);
        rd(SEL_IN_C, 8'h00, "before strobe");
        addrStrobe = 1'b1;
        cycles(2);
        addrStrobe = 1'b0;
        cycles(4);
        rd(SEL_IN_C, 8'h3C, "strobe register");
        check(addressBus, 24'h6B0000, "upper address");
        u_mcu.pins(24'hA57E96);
        cycles(4);
        rd(SEL_IN_C, 8'h3C, "register holds");
        $display("strobe done");
    endtask

    task automatic test_inputs();
        u_mcu.pins(24'hC35A96);
        cycles(4);
        rd(SEL_IN_A, 8'h96, "port A");
        rd(SEL_IN_B, 8'h5A, "port B");
        rd(SEL_IN_C, 8'hC3, "port C");
        for (int i = 8; i < 16; i++) inMode[i] = IN_LATCH;
        inCtlTerm = 6'h3F;
        u_mcu.pins(24'hC38196);
        cycles(4);
        inCtlTerm = 6'h04;
        u_mcu.pins(24'hC37E96);
        cycles(4);
        rd(SEL_IN_B, 8'h8E, "nibble latch");
        check({16'h0, inputBus[15:8]}, 24'h00008E, "latched bus");
        $display("inputs done");
    endtask

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        edgeLoad = 1'b0;
        cellTerms = '0;
        termGrant = 16'h0000;
        directionBit = 16'h0000;
        logicClockPin = 1'b0;
        addrStrobe = 1'b0;
        upperAddress = 8'h00;
        addrCapture = 3'h0;
        inCtlFromStrobe = 6'h00;
        inCtlTerm = 6'h00;
        fails = 0;
        checkCount = 0;
        foreach (inMode[i]) inMode[i] = IN_PASS;
        foreach (cellCfg[i]) cellCfg[i] = '{1'b0, 1'b1, 1'b0, FF_D, 1'b1, 1'b0};
        repeat (2) @(negedge clock);
        rst = 1'b0;
        test_loads();
        test_cells();
        test_pins();
        test_terms();
        test_inputs();
        test_strobe();
        wrap_up();
    end
    initial begin
        #2000000;
        fails++;
        wrap_up();
    end
endmodule // pma_macrocell_array_test
